// [design/gpmct_pkg.sv]
// package for the match/capture timer: register map, field layout,
// reset values, match output actions and the register bus carrier.
// assumes a 32-bit register port with byte addresses, one word each.
package gpmct_pkg;

    // -------------------------------------------------------------
    // widths
    // -------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_MATCH = 4;
    localparam int NUM_PWM = 3;
    localparam int NUM_DMA = 2;
    localparam int FIELD_W = 4;

    // -------------------------------------------------------------
    // register offsets (byte addresses)
    // -------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PRESCALE_LIMIT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PRESCALE_COUNT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_MATCH0 = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_MATCH_CTRL = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_OUT_CTRL = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_PWM_CTRL = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_CAP_CTRL = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_CAP_CLEAR = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_CAP0 = 8'h34;
    localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 8'h44;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h48;
    localparam logic [ADDR_W-1:0] OFS_OUT_STATE = 8'h4c;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_RST_BIT = 1;
    localparam int CTRL_EXT_BIT = 2;
    localparam int MC_INT_BIT = 0;
    localparam int MC_RST_BIT = 1;
    localparam int MC_STOP_BIT = 2;
    localparam int MC_DMA_BIT = 3;
    localparam int CC_RISE_BIT = 0;
    localparam int CC_FALL_BIT = 1;
    localparam int CC_INT_BIT = 2;
    localparam int CLR_EN_BIT = 0;
    localparam int CLR_SEL_LSB = 1;
    localparam int CLR_FALL_BIT = 3;
    localparam int INT_CAP_LSB = 4;
    localparam int PWM_PERIOD_CH = 3;

    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
    localparam logic [NUM_MATCH-1:0] OUT_RESET = 4'h0;

    // match output action, two bits per channel
    typedef enum logic [1:0] {ACT_NONE, ACT_LOW, ACT_HIGH, ACT_TOGGLE} gpmct_act_e;

    // one register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } gpmct_bus_req_s;

endpackage

// [design/gpmct_edge.sv]
// edge finder for the capture inputs and the external count clock.
// assumes inputs already synchronous to core_clk_in.
`timescale 1ns/100ps
module gpmct_edge #(
    parameter int W = 1
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire logic [W-1:0] sig_in,
    output logic [W-1:0] rise_out,
    output logic [W-1:0] fall_out
);

    logic [W-1:0] prev;
    logic primed;

    // -------------------------------------------------------------
    // history
    // -------------------------------------------------------------
    // primed blocks a false edge on the first sample after reset
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prev <= '0;
            primed <= 1'b0;
        end else if (clk_en_in) begin
            prev <= sig_in;
            primed <= 1'b1;
        end
    end

    // edges compare the live input against the last sample
    assign rise_out = primed ? (sig_in & ~prev) : '0;
    assign fall_out = primed ? (~sig_in & prev) : '0;

endmodule

// [design/gpmct_timer.sv]
// general-purpose 32-bit match/capture timer with prescaler.
// assumes one clock, capture and count inputs synchronous to it.
//
// Overview of operation
// - 32-bit counter advances through a software-set 32-bit prescaler.
// - counts system clock cycles or rising edges of an external clock.
// - up to four capture channels load the count on an input edge.
// - a capture event may raise an interrupt when enabled.
// - a chosen capture edge may clear counter and prescaler together.
// - four 32-bit match registers; continue counting, optional interrupt.
// - a match may halt the counter, optionally with an interrupt.
// - a match may reset the counter, optionally with an interrupt.
// - four match outputs go low, high, toggle or stay on match.
// - match channels 0 and 1 may issue timed dma requests.
// - pwm mode: up to three single-edge outputs, match 3 sets period.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/100ps
module gpmct_timer #(
    parameter int NUM_CAP = 4,
    parameter int CNT_W = 32
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire gpmct_pkg::gpmct_bus_req_s bus_in,
    output logic [gpmct_pkg::DATA_W-1:0] rdata_out,
    input wire logic ext_clk_in,
    input wire logic [NUM_CAP-1:0] cap_in,
    output logic [gpmct_pkg::NUM_MATCH-1:0] match_out,
    output logic [gpmct_pkg::NUM_DMA-1:0] dma_req_out,
    output logic irq_out
);
    import gpmct_pkg::*;

    // -------------------------------------------------------------
    // parameter check
    // -------------------------------------------------------------
    if (NUM_CAP < 1 || NUM_CAP > 4 || CNT_W != DATA_W) begin : g_bad_param
        $error("gpmct_timer: NUM_CAP must be 1..4 and CNT_W 32");
    end

    // one bit of a channel's 4-bit field; a call result cannot be bit-selected
    function automatic logic fld(input logic [DATA_W-1:0] v, input int ch, input int b);
        return v[ch*FIELD_W + b];
    endfunction

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic [DATA_W-1:0] ctrl, pr, pc, tc, match_ctrl, out_ctrl, pwm_ctrl;
    logic [DATA_W-1:0] cap_ctrl, cap_clear;
    logic [DATA_W-1:0] mr [NUM_MATCH];
    logic [DATA_W-1:0] cap [NUM_CAP];
    logic [7:0] status, mask, next_status;
    logic [NUM_CAP-1:0] cap_rise, cap_fall, cap_evt;
    logic ext_rise, ext_unused_fall;
    logic tick, pc_wrap, clear_evt, reset_any, stop_any, pwm_any, rst_hold;
    logic [NUM_MATCH-1:0] match_hit;
    logic [1:0] clr_sel;
    logic wr_count;

    // -------------------------------------------------------------
    // input edges
    // -------------------------------------------------------------
    gpmct_edge #(.W(NUM_CAP + 1)) u_edge (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .clk_en_in(clk_en_in),
        .sig_in({ext_clk_in, cap_in}),
        .rise_out({ext_rise, cap_rise}),
        .fall_out({ext_unused_fall, cap_fall})
    );

    // -------------------------------------------------------------
    // count decisions
    // -------------------------------------------------------------
    // one tick per system cycle or per external rising edge
    always_comb begin
        rst_hold = ctrl[CTRL_RST_BIT];
        tick = ctrl[CTRL_EN_BIT] && !rst_hold
            && (ctrl[CTRL_EXT_BIT] ? ext_rise : 1'b1);
        pc_wrap = tick && (pc >= pr);
        wr_count = bus_in.wr && bus_in.addr == OFS_COUNT;
        pwm_any = |pwm_ctrl[NUM_PWM-1:0];
        // a match counts only on the advance out of its value, so once each
        for (int i = 0; i < NUM_MATCH; i++) begin
            match_hit[i] = pc_wrap && (tc == mr[i]);
        end
        reset_any = 1'b0;
        stop_any = 1'b0;
        for (int i = 0; i < NUM_MATCH; i++) begin
            reset_any = reset_any || (match_hit[i] && fld(match_ctrl, i, MC_RST_BIT));
            stop_any = stop_any || (match_hit[i] && fld(match_ctrl, i, MC_STOP_BIT));
        end
        // pwm needs match 3 to restart the period
        reset_any = reset_any || (pwm_any && match_hit[PWM_PERIOD_CH]);
        for (int i = 0; i < NUM_CAP; i++) begin
            cap_evt[i] = (cap_rise[i] && fld(cap_ctrl, i, CC_RISE_BIT))
                || (cap_fall[i] && fld(cap_ctrl, i, CC_FALL_BIT));
        end
        clr_sel = cap_clear[CLR_SEL_LSB +: 2];
        clear_evt = 1'b0;
        if (cap_clear[CLR_EN_BIT] && 32'(clr_sel) < NUM_CAP) begin
            clear_evt = cap_clear[CLR_FALL_BIT] ? cap_fall[clr_sel] : cap_rise[clr_sel];
        end
    end

    // -------------------------------------------------------------
    // prescaler and counter
    // -------------------------------------------------------------
    // clear from capture beats a software write to the count
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pc <= REG_RESET;
            tc <= REG_RESET;
        end else if (clk_en_in) begin
            if (rst_hold || clear_evt) begin
                pc <= REG_RESET;
                tc <= REG_RESET;
            end else if (wr_count) begin
                tc <= bus_in.wdata;
            end else if (pc_wrap) begin
                pc <= REG_RESET;
                if (reset_any) begin
                    tc <= REG_RESET;
                end else if (!stop_any) begin
                    tc <= tc + 32'h0000_0001;
                end
            end else if (tick) begin
                pc <= pc + 32'h0000_0001;
            end
        end
    end

    // -------------------------------------------------------------
    // control register
    // -------------------------------------------------------------
    // a stop match wins over a write that re-enables in the same cycle
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl <= REG_RESET;
        end else if (clk_en_in) begin
            if (bus_in.wr && bus_in.addr == OFS_CTRL) begin
                ctrl <= {29'h0000_0000, bus_in.wdata[2:0]};
            end
            if (stop_any) begin
                ctrl[CTRL_EN_BIT] <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // configuration registers
    // -------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pr <= REG_RESET;
            match_ctrl <= REG_RESET;
            out_ctrl <= REG_RESET;
            pwm_ctrl <= REG_RESET;
            cap_ctrl <= REG_RESET;
            cap_clear <= REG_RESET;
            mask <= REG_RESET[7:0];
            for (int i = 0; i < NUM_MATCH; i++) begin
                mr[i] <= REG_RESET;
            end
        end else if (clk_en_in && bus_in.wr) begin
            if (bus_in.addr == OFS_PRESCALE_LIMIT) begin
                pr <= bus_in.wdata;
            end else if (bus_in.addr == OFS_MATCH_CTRL) begin
                match_ctrl <= {16'h0000, bus_in.wdata[15:0]};
            end else if (bus_in.addr == OFS_OUT_CTRL) begin
                out_ctrl <= {24'h00_0000, bus_in.wdata[7:0]};
            end else if (bus_in.addr == OFS_PWM_CTRL) begin
                pwm_ctrl <= {29'h0000_0000, bus_in.wdata[2:0]};
            end else if (bus_in.addr == OFS_CAP_CTRL) begin
                cap_ctrl <= {16'h0000, bus_in.wdata[15:0]};
            end else if (bus_in.addr == OFS_CAP_CLEAR) begin
                cap_clear <= {28'h000_0000, bus_in.wdata[3:0]};
            end else if (bus_in.addr == OFS_INT_MASK) begin
                mask <= bus_in.wdata[7:0];
            end else begin
                for (int i = 0; i < NUM_MATCH; i++) begin
                    if (bus_in.addr == OFS_MATCH0 + 8'(4 * i)) begin
                        mr[i] <= bus_in.wdata;
                    end
                end
            end
        end
    end

    // -------------------------------------------------------------
    // capture registers
    // -------------------------------------------------------------
    // the count taken is the one before any same-edge clear
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NUM_CAP; i++) begin
                cap[i] <= REG_RESET;
            end
        end else if (clk_en_in) begin
            for (int i = 0; i < NUM_CAP; i++) begin
                if (cap_evt[i]) begin
                    cap[i] <= tc;
                end
            end
        end
    end

    // -------------------------------------------------------------
    // match outputs
    // -------------------------------------------------------------
    // software may also preset the output levels directly
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            match_out <= OUT_RESET;
        end else if (clk_en_in) begin
            if (bus_in.wr && bus_in.addr == OFS_OUT_STATE) begin
                match_out <= bus_in.wdata[NUM_MATCH-1:0];
            end else begin
                for (int i = 0; i < NUM_MATCH; i++) begin
                    if (i < NUM_PWM && pwm_ctrl[i]) begin
                        // low at period start, high from the match on
                        if (match_hit[i]) begin
                            match_out[i] <= 1'b1;
                        end else if (reset_any && pc_wrap) begin
                            match_out[i] <= 1'b0;
                        end
                    end else if (match_hit[i]) begin
                        case (gpmct_act_e'(out_ctrl[2*i +: 2]))
                            ACT_LOW: match_out[i] <= 1'b0;
                            ACT_HIGH: match_out[i] <= 1'b1;
                            ACT_TOGGLE: match_out[i] <= ~match_out[i];
                            default: match_out[i] <= match_out[i];
                        endcase
                    end
                end
            end
        end
    end

    // -------------------------------------------------------------
    // dma requests
    // -------------------------------------------------------------
    // one-cycle request per match, channels 0 and 1 only
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dma_req_out <= '0;
        end else if (clk_en_in) begin
            for (int i = 0; i < NUM_DMA; i++) begin
                dma_req_out[i] <= match_hit[i] && fld(match_ctrl, i, MC_DMA_BIT);
            end
        end
    end

    // -------------------------------------------------------------
    // interrupt status
    // -------------------------------------------------------------
    // read clears; a new event in the reading cycle stays set
    always_comb begin
        next_status = status;
        if (bus_in.rd && bus_in.addr == OFS_INT_STATUS) begin
            next_status = 8'h00;
        end
        for (int i = 0; i < NUM_MATCH; i++) begin
            if (match_hit[i] && fld(match_ctrl, i, MC_INT_BIT)) begin
                next_status[i] = 1'b1;
            end
        end
        for (int i = 0; i < NUM_CAP; i++) begin
            if (cap_evt[i] && fld(cap_ctrl, i, CC_INT_BIT)) begin
                next_status[INT_CAP_LSB + i] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status <= REG_RESET[7:0];
            irq_out <= 1'b0;
        end else if (clk_en_in) begin
            status <= next_status;
            irq_out <= |(next_status & mask);
        end
    end

    // -------------------------------------------------------------
    // register read port
    // -------------------------------------------------------------
    // unmapped addresses and idle cycles read as zero
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out <= REG_RESET;
        end else if (clk_en_in) begin
            rdata_out <= REG_RESET;
            if (bus_in.rd) begin
                if (bus_in.addr == OFS_CTRL) begin
                    rdata_out <= ctrl;
                end else if (bus_in.addr == OFS_PRESCALE_LIMIT) begin
                    rdata_out <= pr;
                end else if (bus_in.addr == OFS_PRESCALE_COUNT) begin
                    rdata_out <= pc;
                end else if (bus_in.addr == OFS_COUNT) begin
                    rdata_out <= tc;
                end else if (bus_in.addr == OFS_MATCH_CTRL) begin
                    rdata_out <= match_ctrl;
                end else if (bus_in.addr == OFS_OUT_CTRL) begin
                    rdata_out <= out_ctrl;
                end else if (bus_in.addr == OFS_PWM_CTRL) begin
                    rdata_out <= pwm_ctrl;
                end else if (bus_in.addr == OFS_CAP_CTRL) begin
                    rdata_out <= cap_ctrl;
                end else if (bus_in.addr == OFS_CAP_CLEAR) begin
                    rdata_out <= cap_clear;
                end else if (bus_in.addr == OFS_INT_STATUS) begin
                    rdata_out <= {24'h00_0000, status};
                end else if (bus_in.addr == OFS_INT_MASK) begin
                    rdata_out <= {24'h00_0000, mask};
                end else if (bus_in.addr == OFS_OUT_STATE) begin
                    rdata_out <= {28'h000_0000, match_out};
                end else begin
                    for (int i = 0; i < NUM_MATCH; i++) begin
                        if (bus_in.addr == OFS_MATCH0 + 8'(4 * i)) begin
                            rdata_out <= mr[i];
                        end
                    end
                    for (int i = 0; i < NUM_CAP; i++) begin
                        if (bus_in.addr == OFS_CAP0 + 8'(4 * i)) begin
                            rdata_out <= cap[i];
                        end
                    end
                end
            end
        end
    end

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_prescale_count_step: assert property (
        clk_en_in && pc_wrap && !clear_evt && !wr_count && !reset_any && !stop_any
        |=> tc == $past(tc) + 32'h0000_0001 && pc == REG_RESET)
        else $error("counter did not advance by one on prescale wrap");
    a_capture_loads_count: assert property (
        clk_en_in && cap_evt[0] |=> cap[0] == $past(tc))
        else $error("capture 0 did not load the count");
    a_capture_clears_count: assert property (
        clk_en_in && clear_evt |=> tc == REG_RESET && pc == REG_RESET)
        else $error("capture clear left counter or prescaler nonzero");
    a_match_reset_zero: assert property (
        clk_en_in && reset_any && !clear_evt && !wr_count |=> tc == REG_RESET)
        else $error("reset on match did not zero the counter");
    a_stop_halts_count: assert property (
        clk_en_in && stop_any && !reset_any && !clear_evt && !wr_count
        |=> !ctrl[CTRL_EN_BIT] && tc == $past(tc))
        else $error("stop on match did not halt counting");
    a_toggle_on_match: assert property (
        clk_en_in && match_hit[0] && !pwm_ctrl[0] && out_ctrl[1:0] == 2'h3
        && !(bus_in.wr && bus_in.addr == OFS_OUT_STATE)
        |=> match_out[0] != $past(match_out[0]))
        else $error("match output 0 did not toggle");
    a_match_irq_raise: assert property (
        clk_en_in && match_hit[1] && match_ctrl[4 + MC_INT_BIT] && mask[1]
        |=> irq_out && status[1])
        else $error("unmasked match interrupt did not reach irq_out");
    a_dma_from_match: assert property (
        clk_en_in && match_hit[0] && match_ctrl[MC_DMA_BIT] |=> dma_req_out[0])
        else $error("dma request missing after match 0");
    a_pwm_high_match: assert property (
        clk_en_in && pwm_ctrl[0] && match_hit[0]
        && !(bus_in.wr && bus_in.addr == OFS_OUT_STATE) |=> match_out[0])
        else $error("pwm output 0 not high after its match");
    a_ext_mode_gate: assert property (
        clk_en_in && ctrl[CTRL_EXT_BIT] && !ext_rise && !rst_hold && !clear_evt && !wr_count
        |=> pc == $past(pc) && tc == $past(tc))
        else $error("external mode counted without an external edge");

    c_pwm_period: cover property (pwm_ctrl[0] && reset_any ##[1:1000] match_hit[0]);
    c_capture_clear: cover property (clear_evt && cap_evt[0]);
    c_stop_match: cover property (stop_any ##1 !ctrl[CTRL_EN_BIT]);

endmodule

// [test/gpmct_far_side.sv]
// far-side model: capture pins and external count clock.
// assumes calls come from the core clock domain.
`timescale 1ns/100ps
module gpmct_far_side (
    input wire logic core_clk_in,
    output logic ext_clk_out,
    output logic [3:0] cap_out
);
    initial begin
        ext_clk_out = 1'b0;
        cap_out = 4'h0;
    end
    // count clock stands low outside a burst
    task automatic ext_burst(input int n);
        repeat (2 * n) begin
            @(posedge core_clk_in);
            ext_clk_out <= ~ext_clk_out;
        end
    endtask
    // one capture pin to a level, held until changed again
    task automatic cap_set(input int ch, input logic v);
        @(posedge core_clk_in);
        cap_out[ch] <= v;
    endtask
endmodule

// [test/gpmct_timer_tb_top.sv]
// bench for the match/capture timer: one task a scenario.
// assumes the far-side model owns capture and count clock pins.
`timescale 1ns/100ps
module gpmct_timer_tb_top;
    import gpmct_pkg::*;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic clk_en = 1'b1;
    gpmct_bus_req_s bus = '0;
    logic [31:0] rdata, d;
    logic ext_clk, irq;
    logic [3:0] cap, mo;
    logic [1:0] dma;
    int mismatches = 0;
    int n_checks = 0;
    always #20 core_clk_in = ~core_clk_in;
    gpmct_far_side u_far (.core_clk_in(core_clk_in), .ext_clk_out(ext_clk), .cap_out(cap));
    gpmct_timer u_dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en),
        .bus_in(bus), .rdata_out(rdata), .ext_clk_in(ext_clk), .cap_in(cap),
        .match_out(mo), .dma_req_out(dma), .irq_out(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // strobes drop one edge later, so tasks never collide in a time step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk_in);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_in);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk_in);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge core_clk_in);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask
    // stop on match: count parks at the match value, irq stays up
    task automatic t_stop();
        rd(8'hfc, d);
        chk(d, 32'h0);
        rd(OFS_PRESCALE_LIMIT, d);
        chk(d, REG_RESET);
        wr(OFS_MATCH0, 32'h3);
        wr(OFS_MATCH_CTRL, 32'h5);
        wr(OFS_OUT_CTRL, 32'h3);
        wr(OFS_INT_MASK, 32'h1);
        wr(OFS_CTRL, 32'h1);
        repeat (20) @(posedge core_clk_in);
        #1 chk({31'h0, irq}, 32'h1);
        chk({31'h0, mo[0]}, 32'h1);
        rd(OFS_COUNT, d);
        chk(d, 32'h3);
        rd(OFS_CTRL, d);
        chk(d, 32'h0);
        rd(OFS_INT_STATUS, d);
        chk(d & 32'h1, 32'h1);
        rd(OFS_INT_STATUS, d);
        chk(d & 32'h1, 32'h0);
    endtask
    // reset on match 1, dma pulses from matches 0 and 1 every third cycle
    task automatic t_reset_dma();
        int n;
        n = 0;
        wr(OFS_CTRL, 32'h2);
        wr(OFS_MATCH0, 32'h1);
        wr(OFS_MATCH0 + 8'h4, 32'h2);
        wr(OFS_MATCH_CTRL, 32'hb8);
        wr(OFS_OUT_CTRL, 32'h8);
        wr(OFS_INT_MASK, 32'h2);
        wr(OFS_CTRL, 32'h1);
        repeat (6) @(posedge core_clk_in);
        repeat (12) begin
            @(posedge core_clk_in);
            #1 n += int'(dma[0] === 1'b1) + int'(dma[1] === 1'b1);
        end
        chk(n, 8);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, mo[1]}, 32'h1);
        rd(OFS_COUNT, d);
        chk({31'h0, d < 3}, 32'h1);
    endtask
    // capture with slow prescaler, then clear on a second rising edge
    task automatic t_capture();
        wr(OFS_CTRL, 32'h2);
        wr(OFS_MATCH_CTRL, 32'h0);
        wr(OFS_PRESCALE_LIMIT, 32'hff);
        wr(OFS_CAP_CTRL, 32'h5);
        wr(OFS_INT_MASK, 32'h10);
        rd(OFS_INT_STATUS, d);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_COUNT, 32'h55);
        u_far.cap_set(0, 1'b1);
        repeat (3) @(posedge core_clk_in);
        #1 chk({31'h0, irq}, 32'h1);
        rd(OFS_CAP0, d);
        chk(d, 32'h55);
        rd(OFS_INT_STATUS, d);
        chk(d & 32'h10, 32'h10);
        wr(OFS_CAP_CLEAR, 32'h1);
        u_far.cap_set(0, 1'b0);
        u_far.cap_set(0, 1'b1);
        repeat (3) @(posedge core_clk_in);
        rd(OFS_COUNT, d);
        chk(d, 32'h0);
        rd(OFS_CAP0, d);
        chk(d, 32'h55);
    endtask
    // counter mode: six outside edges through a divide-by-two prescaler
    task automatic t_ext();
        wr(OFS_CTRL, 32'h2);
        wr(OFS_CAP_CLEAR, 32'h0);
        wr(OFS_PRESCALE_LIMIT, 32'h1);
        wr(OFS_CTRL, 32'h5);
        u_far.ext_burst(6);
        repeat (4) @(posedge core_clk_in);
        rd(OFS_COUNT, d);
        chk(d, 32'h3);
    endtask
    // pwm on output 0: five-count period, high from match 0 to the wrap
    task automatic t_pwm();
        int n;
        n = 0;
        wr(OFS_CTRL, 32'h2);
        wr(OFS_PRESCALE_LIMIT, 32'h0);
        wr(OFS_MATCH0 + 8'hc, 32'h4);
        wr(OFS_MATCH0, 32'h1);
        wr(OFS_OUT_CTRL, 32'h18);
        wr(OFS_OUT_STATE, 32'h4);
        wr(OFS_PWM_CTRL, 32'h1);
        wr(OFS_CTRL, 32'h1);
        repeat (3) @(posedge core_clk_in);
        repeat (10) begin
            @(posedge core_clk_in);
            #1 n += int'(mo[0] === 1'b1);
        end
        chk(n, 6);
        chk({29'h0, mo[3:1]}, 32'h1);
    endtask
    // enable low for ten edges: only the three enabled edges count
    task automatic t_freeze();
        logic [31:0] d0;
        wr(OFS_PWM_CTRL, 32'h0);
        rd(OFS_COUNT, d0);
        @(posedge core_clk_in);
        clk_en <= 1'b0;
        repeat (10) @(posedge core_clk_in);
        clk_en <= 1'b1;
        rd(OFS_COUNT, d);
        chk(d - d0, 32'h3);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        t_stop();
        t_reset_dma();
        t_capture();
        t_ext();
        t_pwm();
        t_freeze();
        complete_run();
    end
    // about 190 cycles expected, so this is ample
    initial begin
        #100000;
        mismatches++;
        complete_run();
    end
endmodule
